// ### core/cmc_mode_ctrl.sv
/*
 global and channel mode controller for a one-channel CAN block.
 assumes the protocol engine supplies bus events on the clk domain through
 the link struct, and software uses the plain register port.
*/
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module cmc_mode_ctrl
   import cmc_pkg::*;
(
   // clock and reset
   input  wire logic      clk,
   input  wire logic      rst,
   // register port
   input  wire cmc_req_t  req,
   output logic [15:0]    rdata,
   // protocol engine
   input  wire cmc_link_t link,
   // gating and state
   output logic           module_clk_en,
   output logic           chan_clk_en,
   output logic           comm_enable,
   output logic           test_write_en,
   output logic [3:0]     mode_state
);
   cmc_gmode_t gmode;
   cmc_cmode_t cmode;
   logic [1:0]  global_mode_request;
   logic        global_sleep_request;
   logic [1:0]  channel_mode_request;
   logic        channel_sleep_request;
   logic [1:0]  busoff_recovery_select;
   logic [8:0]  transmit_error_count;
   logic [7:0]  receive_error_count;
   logic        busoff_state_flag;
   logic        comm_ready_flag;
   logic        global_halt_flag;
   logic [15:0] timestamp_value;
   logic        ram_test_enable;
   logic        rx_fifo_enable;
   logic        common_fifo_enable;
   logic        common_fifo_tx;
   logic [5:0]  common_fifo_count;
   logic [7:0]  chan_test;
   logic [7:0]  global_err;
   logic        idle_seen;
   logic        run_pulse;
   logic        dominant_lock_flag;
   logic [7:0]  run_total;
   logic        enter_greset;
   logic        enter_creset;
   logic        wr_ok;
   logic        chan_wr_ok;
   logic        halt_hold;
   cmc_gmode_t  next_gmode;
   cmc_cmode_t  next_cmode;

   function automatic logic [15:0] pad8(input logic [7:0] v);
      return {8'h00, v};
   endfunction

   assign wr_ok      = req.wr && (gmode != G_SLEEP);
   assign chan_wr_ok = wr_ok && (cmode != C_SLEEP);

   // global mode transitions
   always_comb begin
      next_gmode = gmode;
      if (global_sleep_request) begin
         // sleep only with the channel in reset or sleep
         if (cmode == C_RESET || cmode == C_SLEEP) begin
            next_gmode = G_SLEEP;
         end
      end else begin
         // leaving sleep always goes through reset
         case (global_mode_request)
            GM_OPER:  next_gmode = (gmode == G_SLEEP) ? G_RESET : G_OPER;
            GM_RESET: next_gmode = G_RESET;
            GM_HALT:  next_gmode = (gmode == G_SLEEP) ? G_RESET : G_HALT;
            default:  next_gmode = gmode;
         endcase
      end
   end

   assign enter_greset = (next_gmode == G_RESET) && (gmode != G_RESET);

   // channel mode transitions
   always_comb begin
      next_cmode = cmode;
      case (next_gmode)
         G_RESET: begin
            if (cmode != C_SLEEP) begin
               next_cmode = C_RESET;
            end
         end
         G_SLEEP: begin
            next_cmode = C_SLEEP;
         end
         default: begin
            if (channel_sleep_request) begin
               if (cmode == C_RESET) begin
                  next_cmode = C_SLEEP;
               end
            end else if (cmode == C_SLEEP) begin
               next_cmode = C_RESET;
            end else if (channel_mode_request == CM_RESET) begin
               // reset is immediate regardless of frame state
               next_cmode = C_RESET;
            end else if (channel_mode_request == CM_HALT || next_gmode == G_HALT) begin
               // halt blocked while bus locked dominant
               if (!dominant_lock_flag && (cmode == C_OPER) && !busoff_state_flag) begin
                  next_cmode = C_HALT;
               end else if (!dominant_lock_flag && cmode == C_RESET) begin
                  next_cmode = C_HALT;
               end else if (!dominant_lock_flag && busoff_state_flag
                            && busoff_recovery_select == BO_MANUAL) begin
                  next_cmode = C_HALT;
               end
            end else if (channel_mode_request == CM_OPER && next_gmode == G_OPER && !halt_hold) begin
               if (cmode != C_OPER) begin
                  next_cmode = C_OPER;
               end
            end
            if (cmode == C_OPER && busoff_state_flag && !dominant_lock_flag) begin
               if (busoff_recovery_select == BO_AUTO_TEC && transmit_error_count > TEC_LIMIT) begin
                  next_cmode = C_HALT;
               end
               // recovery after 128 idle runs counted from bus-off entry
               if (busoff_recovery_select == BO_AUTO_IDLE && run_total >= 8'(IDLE_RUNS)) begin
                  next_cmode = C_HALT;
               end
            end
         end
      endcase
   end

   assign enter_creset = (next_cmode == C_RESET) && (cmode != C_RESET);

   always_ff @(posedge clk) begin
      if (rst) begin
         gmode <= G_RESET;
         cmode <= C_RESET;
      end else begin
         gmode <= next_gmode;
         cmode <= next_cmode;
      end
   end

   // a hardware halt holds until the request is rewritten
   always_ff @(posedge clk) begin
      if (rst) begin
         halt_hold <= 1'b0;
      end else if (cmode == C_OPER && next_cmode == C_HALT) begin
         halt_hold <= 1'b1;
      end else if (next_cmode != C_HALT || (req.wr && req.addr == ADR_CHAN_CTRL_LO)) begin
         halt_hold <= 1'b0;
      end
   end

   // global control register
   always_ff @(posedge clk) begin
      if (rst) begin
         global_mode_request  <= GM_RESET;
         global_sleep_request <= 1'b0;
      end else if (req.wr && req.addr == ADR_GLOBAL_CTRL) begin
         // sleep request itself must stay writable to wake
         global_mode_request  <= req.wdata[1:0];
         global_sleep_request <= req.wdata[2];
      end
   end

   // channel control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         channel_mode_request   <= CM_RESET;
         channel_sleep_request  <= 1'b0;
         busoff_recovery_select <= 2'h0;
         chan_test              <= RST_DATA[7:0];
      end else begin
         if (req.wr && req.addr == ADR_CHAN_CTRL_LO && gmode != G_SLEEP) begin
            channel_mode_request  <= req.wdata[1:0];
            channel_sleep_request <= req.wdata[2];
         end else if (enter_greset || enter_creset) begin
            // request field cleared to reset code
            channel_mode_request <= CM_RESET;
         end
         if (chan_wr_ok && req.addr == ADR_CHAN_CTRL_HI && cmode == C_RESET) begin
            busoff_recovery_select <= req.wdata[1:0];
         end
         // channel test registers writable in halt only
         if (chan_wr_ok && req.addr == ADR_CHAN_TEST && cmode == C_HALT) begin
            chan_test <= req.wdata[7:0];
         end
      end
   end

   cmc_idle_det u_idle (
      .clk       (clk),
      .rst       (rst),
      .clear     (cmode != C_OPER || (transmit_error_count > TEC_LIMIT && !busoff_state_flag)),
      .bit_tick  (link.bit_tick),
      .recessive (link.rx_recessive),
      .idle_seen (idle_seen),
      .run_pulse (run_pulse),
      .dom_lock  (dominant_lock_flag),
      .run_total (run_total)
   );

   // error counters and bus-off
   always_ff @(posedge clk) begin
      if (rst || enter_greset || enter_creset) begin
         transmit_error_count <= 9'h000;
         receive_error_count  <= 8'h00;
         busoff_state_flag    <= 1'b0;
      end else if (next_cmode == C_HALT && cmode == C_OPER && busoff_state_flag) begin
         busoff_state_flag    <= 1'b0;
         transmit_error_count <= 9'h000;
      end else if (cmode == C_OPER && gmode == G_OPER) begin
         if (link.tx_error && transmit_error_count <= TEC_LIMIT) begin
            transmit_error_count <= transmit_error_count + 9'h008;
         end else if (link.tx_ok && transmit_error_count != 9'h000 && !busoff_state_flag) begin
            transmit_error_count <= transmit_error_count - 9'h001;
         end
         if (link.rx_error && receive_error_count != 8'hFF) begin
            receive_error_count <= receive_error_count + 8'h01;
         end else if (link.rx_ok && receive_error_count != 8'h00) begin
            receive_error_count <= receive_error_count - 8'h01;
         end
         if (transmit_error_count > TEC_LIMIT) begin
            busoff_state_flag <= 1'b1;
         end
      end
   end

   // ready once 11 recessive bits seen in operation
   always_ff @(posedge clk) begin
      if (rst || cmode != C_OPER) begin
         comm_ready_flag <= 1'b0;
      end else begin
         comm_ready_flag <= idle_seen && !busoff_state_flag;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || enter_greset) begin
         global_halt_flag <= 1'b0;
         timestamp_value  <= RST_DATA;
         ram_test_enable  <= 1'b0;
         rx_fifo_enable   <= 1'b0;
         global_err       <= 8'h00;
      end else begin
         global_halt_flag <= (gmode == G_HALT);
         if (gmode == G_OPER) begin
            timestamp_value <= timestamp_value + 16'h0001;
         end
         // test registers writable in global halt
         if (wr_ok && req.addr == ADR_GLOBAL_TEST && gmode == G_HALT) begin
            ram_test_enable <= req.wdata[0];
         end
         if (wr_ok && req.addr == ADR_FIFO_CTRL && gmode == G_RESET) begin
            rx_fifo_enable <= req.wdata[1];
         end
         if (link.rx_error && cmode == C_OPER) begin
            global_err <= global_err | 8'h01;
         end
      end
   end

   // common fifo reset depends on direction
   always_ff @(posedge clk) begin
      if (rst) begin
         common_fifo_enable <= 1'b0;
         common_fifo_tx     <= 1'b0;
         common_fifo_count  <= 6'h00;
      end else if (enter_greset || (enter_creset && common_fifo_tx)) begin
         common_fifo_enable <= 1'b0;
         common_fifo_count  <= 6'h00;
      end else begin
         if (wr_ok && req.addr == ADR_FIFO_CTRL) begin
            common_fifo_enable <= req.wdata[0];
            if (gmode == G_RESET) begin
               common_fifo_tx <= req.wdata[2];
            end
         end
         if (common_fifo_enable && (link.tx_ok || link.rx_ok) && common_fifo_count != 6'h3F) begin
            common_fifo_count <= common_fifo_count + 6'h01;
         end
      end
   end

   // read port, one cycle latency; reads allowed in sleep
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= RST_DATA;
      end else if (req.rd) begin
         case (req.addr)
            ADR_GLOBAL_CTRL:   rdata <= {13'h0000, global_sleep_request, global_mode_request};
            ADR_GLOBAL_STATUS: rdata <= {13'h0000, gmode == G_SLEEP, global_halt_flag, gmode == G_RESET};
            ADR_CHAN_CTRL_LO:  rdata <= {13'h0000, channel_sleep_request, channel_mode_request};
            ADR_CHAN_CTRL_HI:  rdata <= {14'h0000, busoff_recovery_select};
            ADR_CHAN_STATUS:   rdata <= pad8({dominant_lock_flag, busoff_state_flag,
                                              link.tx_active && comm_ready_flag,
                                              link.rx_active && comm_ready_flag, comm_ready_flag,
                                              cmode == C_SLEEP, cmode == C_HALT, cmode == C_RESET});
            ADR_ERR_COUNT:     rdata <= {transmit_error_count[7:0], receive_error_count};
            ADR_TIMESTAMP:     rdata <= timestamp_value;
            ADR_CHAN_TEST:     rdata <= pad8(chan_test);
            ADR_GLOBAL_TEST:   rdata <= {global_err, 7'h00, ram_test_enable};
            ADR_FIFO_CTRL:     rdata <= {common_fifo_count, 7'h00, common_fifo_tx,
                                         rx_fifo_enable, common_fifo_enable};
            default:           rdata <= RST_DATA;
         endcase
      end else begin
         rdata <= RST_DATA;
      end
   end

   // gating outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         module_clk_en <= 1'b1;
         chan_clk_en   <= 1'b1;
         comm_enable   <= 1'b0;
         test_write_en <= 1'b0;
         mode_state    <= 4'h5;
      end else begin
         // module clock stops in global sleep
         module_clk_en <= (next_gmode != G_SLEEP);
         // channel clock stops in channel sleep
         chan_clk_en   <= (next_cmode != C_SLEEP);
         // traffic only in global operating and channel operation
         comm_enable   <= (next_gmode == G_OPER) && (next_cmode == C_OPER) && comm_ready_flag;
         test_write_en <= (next_gmode == G_HALT) || (next_cmode == C_HALT);
         mode_state    <= {next_gmode, next_cmode};
      end
   end
endmodule // cmc_mode_ctrl
`default_nettype wire

// ### pkg/cmc_pkg.sv
/*
 mode controller package: mode codes, register offsets, field positions,
 reset values and timing counts.
 assumes one channel and a 100 MHz module clock.
*/
`default_nettype none
package cmc_pkg;
   localparam logic [1:0] GM_OPER  = 2'h0;
   localparam logic [1:0] GM_RESET = 2'h1;
   localparam logic [1:0] GM_HALT  = 2'h2;
   localparam logic [1:0] CM_OPER  = 2'h0;
   localparam logic [1:0] CM_RESET = 2'h1;
   localparam logic [1:0] CM_HALT  = 2'h2;
   localparam logic [1:0] BO_AUTO_TEC  = 2'h1;
   localparam logic [1:0] BO_AUTO_IDLE = 2'h2;
   localparam logic [1:0] BO_MANUAL    = 2'h3;
   localparam logic [3:0] ADR_GLOBAL_CTRL   = 4'h0;
   localparam logic [3:0] ADR_GLOBAL_STATUS = 4'h1;
   localparam logic [3:0] ADR_CHAN_CTRL_LO  = 4'h2;
   localparam logic [3:0] ADR_CHAN_CTRL_HI  = 4'h3;
   localparam logic [3:0] ADR_CHAN_STATUS   = 4'h4;
   localparam logic [3:0] ADR_ERR_COUNT     = 4'h5;
   localparam logic [3:0] ADR_TIMESTAMP     = 4'h6;
   localparam logic [3:0] ADR_CHAN_TEST     = 4'h7;
   localparam logic [3:0] ADR_GLOBAL_TEST   = 4'h8;
   localparam logic [3:0] ADR_FIFO_CTRL     = 4'h9;
   localparam int   GLOBAL_STATUS_RESET = 0;
   localparam int   GLOBAL_STATUS_HALT  = 1;
   localparam int   GLOBAL_STATUS_SLEEP = 2;
   localparam int   CS_RESET   = 0;
   localparam int   CS_HALT    = 1;
   localparam int   CS_SLEEP   = 2;
   localparam int   CS_COMM    = 3;
   localparam int   CS_RECV    = 4;
   localparam int   CS_TRANS   = 5;
   localparam int   CS_BUSOFF  = 6;
   localparam int   CS_DOMLOCK = 7;
   localparam int   IDLE_BITS  = 11;
   localparam int   IDLE_RUNS  = 128;
   localparam logic [8:0] TEC_LIMIT = 9'h0FF;
   localparam logic [15:0] RST_DATA = 16'h0000;

   typedef enum logic [1:0] {
      G_OPER  = 2'b00,
      G_RESET = 2'b01,
      G_HALT  = 2'b10,
      G_SLEEP = 2'b11
   } cmc_gmode_t;

   typedef enum logic [1:0] {
      C_OPER  = 2'b00,
      C_RESET = 2'b01,
      C_HALT  = 2'b10,
      C_SLEEP = 2'b11
   } cmc_cmode_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } cmc_req_t;

   typedef struct packed {
      logic bit_tick;
      logic rx_recessive;
      logic rx_active;
      logic tx_active;
      logic tx_error;
      logic rx_error;
      logic tx_ok;
      logic rx_ok;
   } cmc_link_t;
endpackage
`default_nettype wire

// ### core/cmc_idle_det.sv
/*
 counts runs of consecutive recessive bits on the bus.
 assumes bit_tick marks one sample per bit, already in the clk domain.
*/
`timescale 1ns/10ps
`default_nettype none
module cmc_idle_det
   import cmc_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // control
   input  wire logic clear,
   // bus samples
   input  wire logic bit_tick,
   input  wire logic recessive,
   // results
   output logic      idle_seen,
   output logic      run_pulse,
   output logic      dom_lock,
   output logic [7:0] run_total
);
   logic [3:0] ones;
   logic [7:0] zeros;

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         ones      <= 4'h0;
         idle_seen <= 1'b0;
         run_pulse <= 1'b0;
         run_total <= 8'h00;
      end else begin
         run_pulse <= 1'b0;
         if (bit_tick) begin
            if (!recessive) begin
               ones <= 4'h0;
            end else if (ones == 4'(IDLE_BITS - 1)) begin
               // restart so every 11 bits is counted as a separate run
               ones      <= 4'h0;
               idle_seen <= 1'b1;
               run_pulse <= 1'b1;
               if (run_total != 8'hFF) begin
                  run_total <= run_total + 8'h01;
               end
            end else begin
               ones <= ones + 4'h1;
            end
         end
      end
   end

   // long dominant stretch means the bus is locked low
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         zeros    <= 8'h00;
         dom_lock <= 1'b0;
      end else if (bit_tick) begin
         if (recessive) begin
            zeros    <= 8'h00;
            dom_lock <= 1'b0;
         end else if (zeros == 8'hFF) begin
            dom_lock <= 1'b1;
         end else begin
            zeros <= zeros + 8'h01;
         end
      end
   end
endmodule // cmc_idle_det
`default_nettype wire

// ### dv/cmc_mode_ctrl_asserts.sv
/*
 port checker for the mode controller.
 assumes it is bound to cmc_mode_ctrl on one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cmc_mode_ctrl_asserts
   import cmc_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // register port
   input wire cmc_req_t    req,
   input wire logic [15:0] rdata,
   // bus events
   input wire cmc_link_t   link,
   // gating and state
   input wire logic        module_clk_en,
   input wire logic        chan_clk_en,
   input wire logic        comm_enable,
   input wire logic        test_write_en,
   input wire logic [3:0]  mode_state
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [1:0] gm;
   logic [1:0] cm;
   assign gm = mode_state[3:2];
   assign cm = mode_state[1:0];
   // one cycle of slack is allowed where a mode and its effect settle apart
   a_gsleep_clk: assert property (gm == 2'b11 && $past(gm) == 2'b11 |-> !module_clk_en)
      else $error("module clock runs in global sleep");
   a_csleep_clk: assert property (cm == 2'b11 && $past(cm) == 2'b11 |-> !chan_clk_en)
      else $error("channel clock runs in channel sleep");
   a_sleep_read: assert property (req.rd && req.addr == ADR_GLOBAL_STATUS && gm == 2'b11 |=> rdata[2])
      else $error("status read in sleep lost");
   a_comm_oper: assert property (comm_enable |-> mode_state == 4'h0 || $past(mode_state) == 4'h0)
      else $error("traffic outside operation");
   a_comm_idle: assert property ($rose(comm_enable) |-> $past(link.rx_recessive))
      else $error("comm ready without recessive bus");
   a_test_halt: assert property ((gm == 2'b10 || cm == 2'b10) && $past(mode_state) == mode_state
      |-> test_write_en)
      else $error("test registers locked in halt");
   a_ghalt_chan: assert property (gm == 2'b10 && $past(gm) == 2'b10 |-> cm != 2'b00)
      else $error("channel operates in global halt");
   a_greset_chan: assert property (gm == 2'b01 && $past(gm) == 2'b01 |-> cm == 2'b01 || cm == 2'b11)
      else $error("channel not reset in global reset");
   a_gsleep_chan: assert property (gm == 2'b11 && $past(gm) == 2'b11 |-> cm == 2'b11)
      else $error("channel awake in global sleep");
   a_chan_reset_now: assert property (req.wr && req.addr == ADR_CHAN_CTRL_LO && req.wdata[2:0] == 3'b001
      && module_clk_en && chan_clk_en |-> ##[1:3] cm == 2'b01)
      else $error("channel reset not immediate");
   c_full_sleep: cover property (mode_state == 4'hF);
   c_comm_ready: cover property (comm_enable);
   c_both_halt: cover property (mode_state == 4'hA);
endmodule // cmc_mode_ctrl_asserts
bind cmc_mode_ctrl cmc_mode_ctrl_asserts u_chk (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .link(link),
   .module_clk_en(module_clk_en), .chan_clk_en(chan_clk_en), .comm_enable(comm_enable),
   .test_write_en(test_write_en), .mode_state(mode_state));
`default_nettype wire

// ### dv/cmc_bus_node.sv
/*
 model of the other nodes on the bus, seen as bit events.
 assumes one bit every four clocks, same clock as the controller.
*/
`timescale 1ns/10ps
`default_nettype none
module cmc_bus_node
   import cmc_pkg::*;
(
   // clock and reset
   input  wire logic    clk,
   input  wire logic    rst,
   // commands from the bench
   input  wire logic    hold_dominant,
   input  wire logic    force_errors,
   // events toward the channel
   output var cmc_link_t link
);
   logic [1:0] phase;
   always_ff @(posedge clk) begin
      if (rst) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end
   // idle bus is recessive, a stuck bus stays dominant
   always_comb begin
      link = '0;
      link.bit_tick = (phase == 2'h3);
      link.rx_recessive = !hold_dominant;
      link.rx_active = hold_dominant;
      link.tx_error = force_errors && (phase == 2'h3);
   end
endmodule // cmc_bus_node
`default_nettype wire

// ### dv/test_can_mode_controller.sv
/*
 self-checking bench for the mode controller.
 assumes the bound checker and the bus node model.
*/
`timescale 1ns/10ps
`default_nettype none
module test_can_mode_controller
   import cmc_pkg::*;
;
   logic        clk;
   logic        rst;
   cmc_req_t    req;
   logic [15:0] rdata;
   cmc_link_t   link;
   logic        module_clk_en;
   logic        chan_clk_en;
   logic        comm_enable;
   logic        test_write_en;
   logic [3:0]  mode_state;
   logic        hold_dominant;
   logic        force_errors;
   int          num_errors;
   int          check_count;
   int          i;
   // rows: register, write data, mode after it
   localparam logic [23:0] ROWS [8] = '{
      {ADR_GLOBAL_CTRL, 16'h0002, 4'h9}, {ADR_CHAN_CTRL_LO, 16'h0002, 4'hA},
      {ADR_GLOBAL_CTRL, 16'h0000, 4'h2}, {ADR_CHAN_CTRL_LO, 16'h0000, 4'h0},
      {ADR_GLOBAL_CTRL, 16'h0002, 4'hA}, {ADR_GLOBAL_CTRL, 16'h0000, 4'h2},
      {ADR_CHAN_CTRL_LO, 16'h0000, 4'h0}, {ADR_GLOBAL_CTRL, 16'h0001, 4'h5}};

   always #5 clk = ~clk;

   cmc_mode_ctrl uut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .link(link),
      .module_clk_en(module_clk_en), .chan_clk_en(chan_clk_en), .comm_enable(comm_enable),
      .test_write_en(test_write_en), .mode_state(mode_state));
   cmc_bus_node u_node (.clk(clk), .rst(rst), .hold_dominant(hold_dominant),
      .force_errors(force_errors), .link(link));

   function automatic logic [15:0] gs(input logic [1:0] m);
      return (16'h0001 << m) >> 1;
   endfunction

   task automatic tally_and_finish();
      if (num_errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
      // let the transition finish before the next request
      repeat (2) @(posedge clk);
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      check(rdata & m, e);
      @(posedge clk);
   endtask

   task automatic mst(input logic [3:0] e);
      check({12'h000, mode_state}, {12'h000, e});
      rd(ADR_GLOBAL_STATUS, 16'h0007, gs(e[3:2]));
      rd(ADR_CHAN_STATUS, 16'h0007, gs(e[1:0]));
   endtask

   task automatic go_oper();
      for (int k = 0; k < 4; k++) begin
         wr(ROWS[k][23:20], ROWS[k][19:4]);
      end
   endtask

   task automatic bo(input logic [1:0] sel);
      wr(ADR_CHAN_CTRL_HI, {14'h0000, sel});
      go_oper();
      force_errors <= 1'b1;
      for (i = 0; i < 6000 && mode_state[1:0] == 2'b00; i++) @(posedge clk);
      force_errors <= 1'b0;
      if (sel == BO_AUTO_IDLE) begin
         check({15'h0000, i > 5700}, 16'h0001);
      end
      repeat (4) @(posedge clk);
      if (sel == BO_MANUAL) begin
         rd(ADR_CHAN_STATUS, 16'h0040, 16'h0040);
         mst(4'h0);
         wr(ADR_CHAN_CTRL_LO, 16'h0002);
      end else begin
         rd(ADR_ERR_COUNT, 16'hFF00, 16'h0000);
         rd(ADR_CHAN_STATUS, 16'h0040, 16'h0000);
      end
      mst(4'h2);
      wr(ADR_CHAN_TEST, {14'h0000, sel});
      rd(ADR_CHAN_TEST, 16'h00FF, {14'h0000, sel});
      wr(ADR_CHAN_CTRL_LO, 16'h0001);
      mst(4'h1);
      rd(ADR_ERR_COUNT, 16'hFFFF, 16'h0000);
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      req = '0;
      hold_dominant = 1'b0;
      force_errors = 1'b0;
      num_errors = 0;
      check_count = 0;
      repeat (12) @(posedge clk);
      check({11'h000, mode_state, module_clk_en}, 16'h000B);
      check({15'h0000, comm_enable}, 16'h0000);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 8; i++) begin
         wr(ROWS[i][23:20], ROWS[i][19:4]);
         mst(ROWS[i][3:0]);
      end
      rd(4'hF, 16'hFFFF, 16'h0000);
      wr(ADR_CHAN_CTRL_HI, 16'h0001);
      rd(ADR_CHAN_CTRL_HI, 16'h0003, 16'h0001);
      wr(ADR_GLOBAL_CTRL, 16'h0005);
      mst(4'hF);
      check({15'h0000, module_clk_en}, 16'h0000);
      wr(ADR_CHAN_CTRL_HI, 16'h0003);
      rd(ADR_CHAN_CTRL_HI, 16'h0003, 16'h0001);
      wr(ADR_GLOBAL_CTRL, 16'h0001);
      check({14'h0000, mode_state[3:2]}, 16'h0001);
      // a second reset mid-run restores a known channel state
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      mst(4'h5);
      wr(ADR_FIFO_CTRL, 16'h0007);
      go_oper();
      check({15'h0000, comm_enable}, 16'h0000);
      for (i = 0; i < 200 && comm_enable !== 1'b1; i++) @(posedge clk);
      if (comm_enable !== 1'b1) begin
         check(16'h0000, 16'h0001);
         tally_and_finish();
      end
      rd(ADR_CHAN_STATUS, 16'h0008, 16'h0008);
      hold_dominant <= 1'b1;
      repeat (1100) @(posedge clk);
      rd(ADR_CHAN_STATUS, 16'h0080, 16'h0080);
      wr(ADR_CHAN_CTRL_LO, 16'h0002);
      mst(4'h0);
      wr(ADR_CHAN_CTRL_LO, 16'h0001);
      mst(4'h1);
      rd(ADR_FIFO_CTRL, 16'h0007, 16'h0006);
      hold_dominant <= 1'b0;
      rd(ADR_CHAN_STATUS, 16'h0080, 16'h0000);
      bo(BO_AUTO_TEC);
      bo(BO_AUTO_IDLE);
      bo(BO_MANUAL);
      tally_and_finish();
   end
endmodule // test_can_mode_controller
`default_nettype wire
